/* File: core/sblrs_pkg.sv */
// Purpose: shared constants for the break, low-power and reset-status unit
// Assumes: 8-bit registers in the low lanes of a 32-bit APB word
// Notes:   field positions are fixed here and used by sblrs_top and the bench; the counter takes only cnt_w
package sblrs_pkg;
  // register offsets are word indices, not byte addresses
  localparam logic [15:0] off_break_status   = 16'hfe00;
  localparam logic [15:0] off_reset_cause    = 16'hfe01;
  localparam logic [15:0] off_break_flag_ctl = 16'hfe03;
  // decoded address bits; the bus sees four times the index
  localparam int          addr_w             = 18;
  // break status fields
  localparam int          bit_exited_wait    = 1;
  // reset cause fields
  localparam int          bit_rst_lvi        = 1;
  localparam int          bit_rst_monitor    = 2;
  localparam int          bit_rst_illaddr    = 3;
  localparam int          bit_rst_illop      = 4;
  localparam int          bit_rst_watchdog   = 5;
  localparam int          bit_rst_pin        = 6;
  localparam int          bit_rst_por        = 7;
  // break flag control fields
  localparam int          bit_clear_enable   = 7;
  // reset values
  localparam logic [7:0]  rst_break_status   = 8'h00;
  localparam logic [7:0]  rst_reset_cause    = 8'h80;
  localparam logic        rst_clear_enable   = 1'b0;
  // stop recovery timing in oscillator cycles
  localparam int          recov_long_cycles  = 4096;
  localparam int          recov_short_cycles = 32;
  localparam int          cnt_w              = 13;
endpackage

/* File: core/sblrs_recovery_counter.sv */
// Purpose: stop-recovery timer clocked by the oscillator-rate enable
// Assumes: osc_tick is a synchronised one-cycle pulse per oscillator cycle
// Notes:   held clear while hold is high, counts once hold drops
`timescale 1ns/1ps
`default_nettype none
module sblrs_recovery_counter (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      hold,
  input  wire logic                      osc_tick,
  input  wire logic [sblrs_pkg::cnt_w-1:0] target,
  output logic                           done
);
  logic [sblrs_pkg::cnt_w-1:0] count;
  logic [sblrs_pkg::cnt_w-1:0] next_count;
  logic                        reach;

  // counts to the target, then sits
  assign reach      = (count == target);
  assign next_count = hold ? '0 : ((osc_tick && !reach) ? count + 1'b1 : count);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
      done  <= 1'b0;
    end else begin
      count <= next_count;
      done  <= !hold && (next_count == target);
    end
  end

  property p_held_clear;
    @(posedge pclk) disable iff (!presetn) hold |=> (count == '0) && !done;
  endproperty
  a_held_clear: assert property (p_held_clear) else $error("counter not held in stop");
endmodule
`default_nettype wire

/* File: core/sblrs_top.sv */
// Purpose: break flag protection, wait/stop clock gating, reset cause status
// Assumes: cpu, clock generator and reset sources are on pclk; osc tick is a pin
// Notes:   apb slave, zero wait states, 8-bit registers in the low data lane
`timescale 1ns/1ps
`default_nettype none
module sblrs_top (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic             pslverr,
  output logic [31:0]      prdata,
  input  wire logic        power_on_event,
  input  wire logic        pin_reset_event,
  input  wire logic        watchdog_reset_event,
  input  wire logic        illegal_opcode_event,
  input  wire logic        illegal_address_event,
  input  wire logic        monitor_entry_event,
  input  wire logic        low_voltage_event,
  input  wire logic        emulation_mode,
  input  wire logic        short_stop_recovery_option,
  input  wire logic        watchdog_disable_option,
  input  wire logic        wait_exec,
  input  wire logic        stop_exec,
  input  wire logic        module_irq,
  input  wire logic        break_request,
  input  wire logic        break_exit,
  input  wire logic        osc_tick_pin,
  input  wire logic        periph_clear_req,
  output logic             periph_clear_allow,
  output logic             cpu_clock_enable,
  output logic             bus_clock_enable,
  output logic             osc_clock_enable,
  output logic             clear_interrupt_mask,
  output logic             stack_start,
  output logic             force_swi_vector,
  output logic             break_active,
  output logic             watchdog_enable,
  output logic             in_wait,
  output logic             in_stop
);
  typedef enum logic [2:0] {sblrs_run_s, sblrs_wait_s, sblrs_stop_s, sblrs_recov_s} sblrs_state_t;

  sblrs_state_t state;
  sblrs_state_t next_state;
  logic [7:0]   reset_cause;
  logic [7:0]   next_reset_cause;
  logic         exited_wait;
  logic         next_exited_wait;
  logic         clear_enable;
  logic         osc_s1;
  logic         osc_s2;
  logic         osc_s3;
  logic         osc_tick;
  logic         recov_done;
  logic         recov_hold;
  logic [sblrs_pkg::cnt_w-1:0] recov_target;

  // apb decode; offsets are word indices, so the byte address is index*4
  function automatic logic hit(input logic [31:0] a, input logic [15:0] idx);
    hit = (a[sblrs_pkg::addr_w-1:0] == {idx, 2'b00});
  endfunction

  wire acc       = psel && penable;
  wire sel_brk   = hit(paddr, sblrs_pkg::off_break_status);
  wire sel_rst   = hit(paddr, sblrs_pkg::off_reset_cause);
  wire sel_ctl   = hit(paddr, sblrs_pkg::off_break_flag_ctl);
  wire mapped    = sel_brk || sel_rst || sel_ctl;
  wire wr_ctl    = acc && pwrite && sel_ctl;
  wire wr_brk    = acc && pwrite && sel_brk;
  wire rd_rst    = acc && !pwrite && sel_rst;
  wire any_reset = power_on_event || pin_reset_event || watchdog_reset_event ||
                   illegal_opcode_event || illegal_address_event ||
                   monitor_entry_event || low_voltage_event;

  wire [7:0] brk_view = {6'h00, exited_wait && emulation_mode, 1'b0};
  wire [7:0] ctl_view = {clear_enable, 7'h00};
  wire [7:0] rd_byte  = sel_brk ? brk_view :
                        sel_rst ? reset_cause :
                        sel_ctl ? ctl_view : 8'h00;

  // oscillator tick comes from a pin, two flops first, then edge detect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_tick_pin;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end
  assign osc_tick = osc_s2 && !osc_s3;

  assign recov_target = short_stop_recovery_option ?
                        sblrs_pkg::cnt_w'(sblrs_pkg::recov_short_cycles) :
                        sblrs_pkg::cnt_w'(sblrs_pkg::recov_long_cycles);
  assign recov_hold = (state != sblrs_recov_s);

  sblrs_recovery_counter u_recov (
    .pclk     (pclk),
    .presetn  (presetn),
    .hold     (recov_hold),
    .osc_tick (osc_tick),
    .target   (recov_target),
    .done     (recov_done)
  );

  // low-power state walk, reset aborts all modes
  always_comb begin
    next_state = state;
    case (state)
      sblrs_run_s: begin
        if (stop_exec) next_state = sblrs_stop_s;
        else if (wait_exec) next_state = sblrs_wait_s;
      end
      sblrs_wait_s: begin
        if (module_irq || break_request) next_state = sblrs_run_s;
      end
      sblrs_stop_s: begin
        if (break_request) next_state = sblrs_run_s;
        else if (module_irq) next_state = sblrs_recov_s;
      end
      sblrs_recov_s: begin
        if (recov_done) next_state = sblrs_run_s;
      end
      default: next_state = sblrs_run_s;
    endcase
    if (any_reset) next_state = sblrs_run_s;
  end

  // reset causes set over read clear
  always_comb begin
    next_reset_cause = rd_rst ? 8'h00 : reset_cause;
    next_reset_cause[sblrs_pkg::bit_rst_pin]      |= pin_reset_event;
    next_reset_cause[sblrs_pkg::bit_rst_watchdog] |= watchdog_reset_event;
    next_reset_cause[sblrs_pkg::bit_rst_illop]    |= illegal_opcode_event;
    next_reset_cause[sblrs_pkg::bit_rst_illaddr]  |= illegal_address_event;
    next_reset_cause[sblrs_pkg::bit_rst_monitor]  |= monitor_entry_event;
    next_reset_cause[sblrs_pkg::bit_rst_lvi]      |= low_voltage_event;
    if (power_on_event) next_reset_cause = sblrs_pkg::rst_reset_cause;
  end

  // break exiting wait in emulation mode sets flag; set beats software clear
  always_comb begin
    next_exited_wait = exited_wait;
    if (wr_brk && !pwdata[sblrs_pkg::bit_exited_wait]) next_exited_wait = 1'b0;
    if (state == sblrs_wait_s && break_request && emulation_mode) next_exited_wait = 1'b1;
  end

  // state, status and control registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state        <= sblrs_run_s;
      reset_cause  <= sblrs_pkg::rst_reset_cause;
      exited_wait  <= 1'b0;
      clear_enable <= sblrs_pkg::rst_clear_enable;
    end else begin
      state        <= next_state;
      reset_cause  <= next_reset_cause;
      exited_wait  <= next_exited_wait;
      if (wr_ctl) clear_enable <= pwdata[sblrs_pkg::bit_clear_enable];
    end
  end

  // break state follows request until the cpu returns from the break handler
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      break_active     <= 1'b0;
      force_swi_vector <= 1'b0;
    end else begin
      if (break_request) break_active <= 1'b1;
      else if (break_exit || any_reset) break_active <= 1'b0;
      force_swi_vector <= break_request && !break_active;
    end
  end

  // clear permission; a pending first step cannot finish in protected break
  wire next_clear_allow = periph_clear_req && (!(break_active || break_request) || clear_enable);

  // registered control outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      periph_clear_allow   <= 1'b0;
      cpu_clock_enable     <= 1'b1;
      bus_clock_enable     <= 1'b1;
      osc_clock_enable     <= 1'b1;
      clear_interrupt_mask <= 1'b0;
      stack_start          <= 1'b0;
      watchdog_enable      <= 1'b1;
      in_wait              <= 1'b0;
      in_stop              <= 1'b0;
    end else begin
      periph_clear_allow   <= next_clear_allow;
      // cpu clock off in wait and stop
      cpu_clock_enable     <= (next_state == sblrs_run_s);
      // clock generator outputs off in stop
      bus_clock_enable     <= (next_state != sblrs_stop_s);
      osc_clock_enable     <= (next_state != sblrs_stop_s);
      clear_interrupt_mask <= (state == sblrs_run_s) && (wait_exec || stop_exec);
      // stacking one cycle after wake, or after recovery
      stack_start          <= ((state == sblrs_wait_s) && module_irq && !any_reset &&
                               !break_request) ||
                              ((state == sblrs_recov_s) && recov_done && !any_reset);
      watchdog_enable      <= !watchdog_disable_option;
      in_wait              <= (next_state == sblrs_wait_s);
      in_stop              <= (next_state == sblrs_stop_s) || (next_state == sblrs_recov_s);
    end
  end

  // apb read data and status, zero wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata  <= (psel && !penable && !pwrite) ? {24'h000000, rd_byte} : 32'h0000_0000;
    end
  end

  property p_protect;
    @(posedge pclk) disable iff (!presetn)
      (break_active && !clear_enable) |=> !periph_clear_allow;
  endproperty
  a_protect: assert property (p_protect) else $error("flag clear leaked in break");

  property p_enable_clear;
    @(posedge pclk) disable iff (!presetn)
      (periph_clear_req && clear_enable) |=> periph_clear_allow;
  endproperty
  a_enable_clear: assert property (p_enable_clear) else $error("enabled clear lost");

  property p_mask;
    @(posedge pclk) disable iff (!presetn)
      (state == sblrs_run_s && wait_exec) |=> clear_interrupt_mask;
  endproperty
  a_mask: assert property (p_mask) else $error("mask not cleared");

  property p_wait_clk;
    @(posedge pclk) disable iff (!presetn) in_wait |-> !cpu_clock_enable && bus_clock_enable;
  endproperty
  a_wait_clk: assert property (p_wait_clk) else $error("wait clock gating wrong");

  property p_wake;
    @(posedge pclk) disable iff (!presetn)
      (state == sblrs_wait_s && module_irq && !any_reset && !break_request) |=>
        stack_start && cpu_clock_enable && !in_wait;
  endproperty
  a_wake: assert property (p_wake) else $error("no stacking after wake");

  property p_stop_clk;
    @(posedge pclk) disable iff (!presetn)
      in_stop && (state == sblrs_stop_s) |-> !osc_clock_enable && !bus_clock_enable;
  endproperty
  a_stop_clk: assert property (p_stop_clk) else $error("clocks on in stop");

  property p_rc;
    @(posedge pclk) disable iff (!presetn) (rd_rst && !any_reset) |=> reset_cause == 8'h00;
  endproperty
  a_rc: assert property (p_rc) else $error("read did not clear causes");

  property p_por;
    @(posedge pclk) disable iff (!presetn) power_on_event |=> reset_cause == 8'h80;
  endproperty
  a_por: assert property (p_por) else $error("power-on pattern wrong");

  property p_emul;
    @(posedge pclk) disable iff (!presetn) !emulation_mode |-> brk_view == 8'h00;
  endproperty
  a_emul: assert property (p_emul) else $error("break status visible");

  // break entry, wait and stop exit, control writes and pin cause; stacking must never beat the recovery timer
  property p_swi;
    @(posedge pclk) disable iff (!presetn)
      (break_request && !break_active) |=> force_swi_vector && break_active;
  endproperty
  a_swi: assert property (p_swi) else $error("break did not force vector");

  property p_brk_wait;
    @(posedge pclk) disable iff (!presetn)
      (state == sblrs_wait_s && break_request && emulation_mode) |=> exited_wait && !in_wait;
  endproperty
  a_brk_wait: assert property (p_brk_wait) else $error("wait break not flagged");

  property p_stop_irq;
    @(posedge pclk) disable iff (!presetn)
      (state == sblrs_stop_s && module_irq && !break_request && !any_reset) |=>
        in_stop && !stack_start && !cpu_clock_enable;
  endproperty
  a_stop_irq: assert property (p_stop_irq) else $error("stacked before recovery");

  property p_recov_wait;
    @(posedge pclk) disable iff (!presetn)
      (state == sblrs_recov_s && !recov_done && !any_reset) |=> !stack_start && in_stop;
  endproperty
  a_recov_wait: assert property (p_recov_wait) else $error("recovery cut short");

  property p_ctl_set;
    @(posedge pclk) disable iff (!presetn)
      (wr_ctl && pwdata[sblrs_pkg::bit_clear_enable]) |=> clear_enable;
  endproperty
  a_ctl_set: assert property (p_ctl_set) else $error("clear enable not written");

  property p_cause_pin;
    @(posedge pclk) disable iff (!presetn)
      (pin_reset_event && !power_on_event) |=> reset_cause[sblrs_pkg::bit_rst_pin];
  endproperty
  a_cause_pin: assert property (p_cause_pin) else $error("pin reset not recorded");

  c_wait_wake: cover property (@(posedge pclk) disable iff (!presetn) in_wait ##1 stack_start);
  c_recov:     cover property (@(posedge pclk) disable iff (!presetn)
                               state == sblrs_recov_s ##1 stack_start);
  c_rd_rst:    cover property (@(posedge pclk) disable iff (!presetn) rd_rst);
  c_brk_wait:  cover property (@(posedge pclk) disable iff (!presetn)
                               next_exited_wait && !exited_wait);
  c_stop_brk:  cover property (@(posedge pclk) disable iff (!presetn)
                               state == sblrs_stop_s && break_request);
endmodule
`default_nettype wire

/* File: tb/sblrs_far_end.sv */
// Purpose: far-side stand-in: free oscillator pin and one peripheral status flag
// Assumes: six pclk cycles per oscillator cycle, slow enough for the pin sync
// Notes:   the flag clears in two steps; step two needs an allowed clear
`timescale 1ns/1ps
`default_nettype none
module sblrs_far_end (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic set_flag,
  input  wire logic clear_try,
  input  wire logic periph_clear_allow,
  output logic      periph_clear_req,
  output logic      osc_tick_pin,
  output logic      flag
);
  logic [1:0] div;
  logic       pend;
  logic       armed;
  // oscillator pin plus the peripheral's flag and clear request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {div, osc_tick_pin, periph_clear_req, pend, armed, flag} <= '0;
    end else begin
      div <= (div == 2'h2) ? 2'h0 : div + 2'h1;
      if (div == 2'h2) osc_tick_pin <= !osc_tick_pin;
      periph_clear_req <= clear_try;
      pend <= periph_clear_req;
      // step one arms, step two clears only if allowed
      if (set_flag) begin
        flag <= 1'b1;
        armed <= 1'b0;
      end else if (pend && !armed) begin
        armed <= 1'b1;
      end else if (pend && periph_clear_allow) begin
        flag <= 1'b0;
        armed <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

/* File: tb/sblrs_top_tb.sv */
// Purpose: self-checking bench for the break, low-power and reset-status unit
// Assumes: zero-wait apb slave; oscillator tick every six pclk cycles
// Notes:   stop recovery is checked within a window for sync and tick phase
`timescale 1ns/1ps
`default_nettype none
module sblrs_top_tb;
  localparam logic [31:0] a_bs = {14'h0, sblrs_pkg::off_break_status, 2'b00};
  localparam logic [31:0] a_rc = {14'h0, sblrs_pkg::off_reset_cause, 2'b00};
  localparam logic [31:0] a_bc = {14'h0, sblrs_pkg::off_break_flag_ctl, 2'b00};
  // bit of each one-cycle input in the pulse vector
  localparam int pb_wait = 0, pb_stop = 1, pb_brk = 2, pb_brk_exit = 3;
  localparam int pb_clear = 4, pb_set = 5, pb_cause0 = 6;
  logic        pclk, presetn, psel, penable, pwrite, emulation_mode, module_irq, er;
  logic        short_stop_recovery_option, watchdog_disable_option;
  logic [31:0] paddr, pwdata, rd, d;
  logic [12:0] pl;
  logic [7:0]  model_cause;
  logic        pready, pslverr, periph_clear_allow, cpu_clock_enable, bus_clock_enable;
  logic        osc_clock_enable, clear_interrupt_mask, stack_start, force_swi_vector;
  logic        break_active, watchdog_enable, in_wait, in_stop, periph_clear_req;
  logic        osc_tick_pin, flag;
  logic [31:0] prdata;
  wire logic   power_on_event, pin_reset_event, watchdog_reset_event, illegal_opcode_event;
  wire logic   illegal_address_event, monitor_entry_event, low_voltage_event, set_flag;
  wire logic   clear_try, break_exit, break_request, stop_exec, wait_exec;
  int          miscompares, samples_checked, cycles, swi_seen, mask_seen, exp_mask;
  // one-cycle pulses share one vector so a single task drives them
  assign {power_on_event, pin_reset_event, watchdog_reset_event, illegal_opcode_event,
          illegal_address_event, monitor_entry_event, low_voltage_event, set_flag,
          clear_try, break_exit, break_request, stop_exec, wait_exec} = pl;
  sblrs_top u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .prdata,
    .power_on_event, .pin_reset_event, .watchdog_reset_event, .illegal_opcode_event,
    .illegal_address_event, .monitor_entry_event, .low_voltage_event, .emulation_mode,
    .short_stop_recovery_option, .watchdog_disable_option, .wait_exec, .stop_exec,
    .module_irq, .break_request, .break_exit, .osc_tick_pin, .periph_clear_req,
    .periph_clear_allow, .cpu_clock_enable, .bus_clock_enable, .osc_clock_enable,
    .clear_interrupt_mask, .stack_start, .force_swi_vector, .break_active,
    .watchdog_enable, .in_wait, .in_stop
  );
  sblrs_far_end u_far (
    .pclk, .presetn, .set_flag, .clear_try, .periph_clear_allow, .periph_clear_req,
    .osc_tick_pin, .flag
  );
  // clock
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  // pulse counters and the hang limit; long stop recovery dominates run time
  always @(posedge pclk) begin
    cycles++;
    if (clear_interrupt_mask === 1'b1) mask_seen++;
    if (force_swi_vector === 1'b1) swi_seen++;
    if (cycles == 40000) begin
      miscompares++;
      $display("MISMATCH t=%0t run timed out", $time);
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic pulse(input int b);
    @(posedge pclk);
    pl <= 13'h1 << b;
    @(posedge pclk);
    pl <= 13'h0;
  endtask
  // apb transfer: hold everything until pready is sampled high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_cause();
    apb(1'b0, a_rc, 32'h0);
    chk(rd, {24'h0, model_cause});
    model_cause = 8'h00;
  endtask
  // stop with a given recovery length in oscillator ticks
  task automatic stop_run(input logic s, input int ticks);
    int n;
    n = 0;
    short_stop_recovery_option <= s;
    pulse(pb_stop);
    idle(1);
    exp_mask++;
    chk({in_stop, bus_clock_enable, osc_clock_enable, cpu_clock_enable}, 4'h8);
    module_irq <= 1'b1;
    do idle(1); while (stack_start !== 1'b1 && ++n < 30000);
    chk(n >= ticks * 6 - 6 && n <= ticks * 6 + 12, 1);
    module_irq <= 1'b0;
    idle(3);
    chk({in_stop, bus_clock_enable, osc_clock_enable}, 3'h3);
    chk(mask_seen, exp_mask);
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata, pl, module_irq} = '0;
    {emulation_mode, short_stop_recovery_option, watchdog_disable_option} = '0;
    model_cause = 8'h80;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    d = $urandom(52);
    // reset values, power-on cause, unmapped access
    apb(1'b0, a_bs, 32'h0);
    chk(rd, 32'h0);
    rd_cause();
    rd_cause();
    apb(1'b0, 32'h0003f808, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    $display("test reset_values done");
    // every reset cause alone, cleared by the read
    for (int i = 0; i < 7; i++) begin
      pulse(pb_cause0 + i);
      model_cause = (i == 6) ? 8'h80 : (8'h01 << (i + 1));
      rd_cause();
      rd_cause();
    end
    $display("test reset_causes done");
    d = $urandom;
    apb(1'b1, a_bc, d);
    apb(1'b0, a_bc, 32'h0);
    chk(rd, {24'h0, d[7], 7'h0});
    // protected break: a two-step clear started before the break
    apb(1'b1, a_bc, 32'h0);
    pulse(pb_set);
    pulse(pb_clear);
    idle(3);
    pulse(pb_brk);
    idle(2);
    chk({break_active, 31'h0} | swi_seen, 32'h80000001);
    pulse(pb_clear);
    idle(4);
    chk(flag, 1);
    pulse(pb_brk_exit);
    idle(2);
    chk(break_active, 0);
    pulse(pb_clear);
    idle(4);
    chk(flag, 0);
    // clear enabled in break; stays cleared after it
    apb(1'b1, a_bc, 32'h80);
    pulse(pb_set);
    pulse(pb_brk);
    pulse(pb_clear);
    idle(3);
    pulse(pb_clear);
    idle(4);
    chk(flag, 0);
    pulse(pb_brk_exit);
    idle(4);
    chk(flag, 0);
    $display("test break_protect done");
    // wait entry and interrupt wake, watchdog option random
    for (int i = 0; i < 2; i++) begin
      watchdog_disable_option <= 1'($urandom);
      pulse(pb_wait);
      idle(1);
      exp_mask++;
      chk({in_wait, cpu_clock_enable, bus_clock_enable, osc_clock_enable}, 4'hb);
      chk(watchdog_enable, !watchdog_disable_option);
      module_irq <= 1'b1;
      idle(2);
      chk(stack_start, 1);
      module_irq <= 1'b0;
      idle(2);
      chk({in_wait, cpu_clock_enable, 30'h0} | mask_seen, 32'h40000000 | exp_mask);
    end
    // break ends wait and is flagged only in emulation mode
    emulation_mode <= 1'b1;
    pulse(pb_wait);
    exp_mask++;
    pulse(pb_brk);
    idle(2);
    chk(in_wait, 0);
    apb(1'b0, a_bs, 32'h0);
    chk(rd, 32'h2);
    emulation_mode <= 1'b0;
    apb(1'b0, a_bs, 32'h0);
    chk(rd, 32'h0);
    emulation_mode <= 1'b1;
    apb(1'b1, a_bs, 32'h0);
    apb(1'b0, a_bs, 32'h0);
    chk(rd, 32'h0);
    pulse(pb_brk_exit);
    // stop ended by break, then wait ended by a pin reset
    pulse(pb_stop);
    exp_mask++;
    pulse(pb_brk);
    idle(2);
    chk({in_stop, break_active, bus_clock_enable}, 3'h3);
    pulse(pb_brk_exit);
    pulse(pb_wait);
    exp_mask++;
    pulse(pb_cause0 + 5);
    idle(2);
    chk(in_wait, 0);
    model_cause = 8'h01 << sblrs_pkg::bit_rst_pin;
    rd_cause();
    $display("test wait_mode done");
    // stop recovery, short then long
    stop_run(1'b1, sblrs_pkg::recov_short_cycles);
    stop_run(1'b0, sblrs_pkg::recov_long_cycles);
    $display("test stop_mode done");
    print_verdict();
  end
endmodule
`default_nettype wire
